// file: tb/dcr_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Control channel master: one strobe per access, launched on the falling edge
module dcr_mcu_model (
	// Clock
	input wire logic clk_i,
	// Register port
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i
);
	// Idle port
	initial
	begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Write: strobe for exactly one rising edge, then scramble the released lines
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : wr

	// Read: strobe one edge, then take data when the answer shows, bounded
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		for (int n = 0; n < 4 && !ok; n++)
		begin
			if (rvalid_i === 1'b1)
			begin
				d = rdata_i;
				ok = 1'b1;
			end
			else
				@(negedge clk_i);
		end
	endtask : rd
endmodule : dcr_mcu_model
`default_nettype wire

// file: tb/test_dcr_regs_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_dcr_regs_top import dcr_pkg::*;;
	logic clk = 1'b0, rst_n = 1'b0, vs = 1'b0, hs = 1'b0, det = 1'b0, cor = 1'b0;
	logic strap = 1'b1, gpi = 1'b0, pa = 1'b1, pb = 1'b1;
	logic [7:0] addr, wdata, rdata, dm, cm;
	logic wr, rd, rvalid, vs_o, hs_o, err, double_rate_select, eq, stag, ack, gfw, pa_o, pa_oe, pb_o, pb_oe;
	logic [6:0] sa, da, sb, db;
	logic [1:0] sh_sel, to_sel;
	logic [2:0] br_sel;
	logic [7:0] sh [0:31];
	logic [31:0] seed = 32'h78C724D4;
	int error_cnt = 0, compares = 0;
	wire logic pa_w = pa_oe ? 1'b0 : pa;
	wire logic pb_w = pb_oe ? 1'b0 : pb;

	// Clock
	always #20 clk = ~clk;

	dcr_mcu_model mcu (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
		.rdata_i(rdata), .rvalid_i(rvalid));
	dcr_regs_top DUT (.CLK_SYS_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
		.VSYNC_I(vs), .HSYNC_I(hs), .VSYNC_O(vs_o), .HSYNC_O(hs_o), .DET_ERR_I(det),
		.CORR_ERR_I(cor), .ERR_O(err), .DOUBLE_RATE_PIN_I(strap), .DOUBLE_RATE_SELECT_O(double_rate_select),
		.RATE_SETTING_EQUAL_O(eq), .STAGGER_DISABLE_O(stag), .XLATE_SRC_FIRST_O(sa),
		.XLATE_DST_FIRST_O(da), .XLATE_SRC_SECOND_O(sb), .XLATE_DST_SECOND_O(db),
		.LOCAL_ACK_ENABLE_O(ack), .SLAVE_SETUP_HOLD_SEL_O(sh_sel), .MASTER_BITRATE_SEL_O(br_sel),
		.SLAVE_TIMEOUT_SEL_O(to_sel), .GPI_PIN_I(gpi), .GPI_FORWARD_O(gfw), .PIO_A_I(pa_w),
		.PIO_A_O(pa_o), .PIO_A_OE_O(pa_oe), .PIO_B_I(pb_w), .PIO_B_O(pb_o), .PIO_B_OE_O(pb_oe));

	////////////////////////////////////////////////////////////////////////
	// Stimulus source and expectations
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			OFS_CTRL: return sh[8] & CTRL_WMASK;
			OFS_SRC_A, OFS_DST_A, OFS_SRC_B, OFS_DST_B: return sh[a] & 8'hFE;
			OFS_TIM, OFS_DET_THR, OFS_COR_THR: return sh[a];
			OFS_GPIO: return {2'h1, sh[14][5], gpi, sh[14][3], pb_w, sh[14][1], pa_w};
			OFS_DET_CNT: return dm;
			OFS_COR_CNT: return cm;
			default: return 8'h00;
		endcase
	endfunction : exp_rd

	function automatic logic exp_err();
		logic dh, ch;
		dh = dm != 8'h00 && dm >= sh[15];
		ch = cm != 8'h00 && cm >= sh[17];
		case (sh[8][1:0])
			2'h0: return dh;
			2'h1: return ch;
			2'h2: return dh | ch;
			default: return dh & ch;
		endcase
	endfunction : exp_err

	////////////////////////////////////////////////////////////////////////
	// Compare, verdict and bus helpers
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic end_of_test();
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	task automatic w(input logic [7:0] a, input logic [7:0] d);
		mcu.wr(a, d);
		if (a inside {[8'h08:8'h0F], 8'h11})
			sh[a] = d;
		repeat (4) @(negedge clk);
	endtask : w

	task automatic rdc(input logic [7:0] a);
		logic [7:0] d;
		logic ok;
		mcu.rd(a, d, ok);
		if (!ok)
		begin
			error_cnt++;
			end_of_test();
		end
		else
		begin
			chk("rdata", d, exp_rd(a));
			if (sh[8][2] && a == OFS_DET_CNT)
				dm = 8'h00;
			if (sh[8][2] && a == OFS_COR_CNT)
				cm = 8'h00;
		end
	endtask : rdc

	task automatic pulse(input logic d, input logic c, input int n);
		@(negedge clk);
		det = d;
		cor = c;
		repeat (n) @(negedge clk);
		det = 1'b0;
		cor = 1'b0;
		repeat (n) dm = (d && dm != 8'hFF) ? dm + 8'h01 : dm;
		repeat (n) cm = (c && cm != 8'hFF) ? cm + 8'h01 : cm;
		repeat (3) @(negedge clk);
	endtask : pulse

	task automatic do_rst();
		@(negedge clk);
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		foreach (sh[i]) sh[i] = 8'h00;
		sh[13] = RST_TIM;
		sh[14] = RST_GPIO;
		dm = 8'h00;
		cm = 8'h00;
		repeat (3) @(negedge clk);
	endtask : do_rst

	// Port-level view of every control field except the sync inversion and autoclear bits
	task automatic outs();
		chk("tim", {ack, sh_sel, br_sel, to_sel}, sh[13]);
		chk("ctl", {3'h0, eq, stag, 3'h0}, sh[8] & 8'h18);
		chk("xa", {sa, 1'b0}, sh[9] & 8'hFE);
		chk("xad", {da, 1'b0}, sh[10] & 8'hFE);
		chk("xb", {sb, 1'b0}, sh[11] & 8'hFE);
		chk("xbd", {db, 1'b0}, sh[12] & 8'hFE);
		chk("pio", {3'h0, pb_o, pb_oe, pa_o, pa_oe, gfw},
			{3'h0, sh[14][3], ~sh[14][3], sh[14][1], ~sh[14][1], sh[14][5] & gpi});
		chk("dbl", {7'h0, double_rate_select}, {7'h0, strap});
		chk("err", {7'h0, err}, {7'h0, exp_err()});
		for (int a = 0; a < 21; a++)
			rdc(a[7:0]);
	endtask : outs

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		logic [31:0] r;
		do_rst();
		outs();
		// Random writes, pin levels and sync inversion
		for (int i = 0; i < 40; i++)
		begin
			r = xs();
			w(8'h08 + r[7:0] % 8'h0D, r[15:8]);
			{gpi, pa, pb, vs, hs} = r[20:16];
			repeat (4) @(negedge clk);
			chk("sync", {6'h0, vs_o, hs_o}, {6'h0, vs ^ sh[8][7], hs ^ sh[8][6]});
			chk("err", {7'h0, err}, {7'h0, exp_err()});
			rdc(8'h08 + r[7:0] % 8'h0D);
		end
		outs();
		// Threshold, select codes, saturation and autoclear after a mid-run reset
		do_rst();
		w(OFS_DET_THR, 8'h03);
		w(OFS_COR_THR, 8'h02);
		pulse(1'b1, 1'b1, 1);
		pulse(1'b1, 1'b0, 1);
		chk("err", {7'h0, err}, 8'h00);
		pulse(1'b1, 1'b0, 1);
		for (int e = 0; e < 4; e++)
		begin
			w(OFS_CTRL, e[7:0]);
			chk("err", {7'h0, err}, {7'h0, exp_err()});
		end
		pulse(1'b1, 1'b1, 300);
		outs();
		w(OFS_CTRL, 8'h04);
		rdc(OFS_DET_CNT);
		rdc(OFS_COR_CNT);
		outs();
		strap = 1'b0;
		do_rst();
		outs();
		end_of_test();
	end
endmodule : test_dcr_regs_top
`default_nettype wire

// file: verilog/dcr_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
// Event, clear and count of one error counter
interface dcr_cnt_if #(parameter int W = 8);
	logic inc;
	logic clr;
	logic [W-1:0] cnt;
	modport owner (input inc, input clr, output cnt);
	modport user (output inc, output clr, input cnt);
endinterface : dcr_cnt_if
`default_nettype wire

// file: verilog/dcr_err_counter.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_err_counter import dcr_pkg::*; #(
	parameter int W = CNT_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Counter event, clear and value
	dcr_cnt_if.owner cnt_if
);
	logic [W-1:0] cnt_r, cnt_nxt;

	if (W < 1 || W != $bits(cnt_if.cnt))
	begin : g_chk
		$error("dcr_err_counter width does not match its interface");
	end

	// Saturating count; an event in the clearing cycle still counts
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (cnt_if.clr)
			cnt_nxt = cnt_if.inc ? W'(1) : '0;
		else if (cnt_if.inc && cnt_r != {W{1'b1}})
			cnt_nxt = cnt_r + W'(1);
	end

	// Count register
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign cnt_if.cnt = cnt_r;

	// Checks on the counter
	sat_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(cnt_r == {W{1'b1}} && !cnt_if.clr) |=> cnt_r == {W{1'b1}})
		else $error("counter left saturation without clear");
	set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(cnt_if.clr && cnt_if.inc) |=> cnt_r == W'(1))
		else $error("event lost during clear");
	count_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!cnt_if.clr && cnt_if.inc && cnt_r != {W{1'b1}}) |=> cnt_r == $past(cnt_r) + W'(1))
		else $error("counter did not step by one");
endmodule : dcr_err_counter
`default_nettype wire

// file: verilog/dcr_pkg.sv
package dcr_pkg;
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_SRC_A = 8'h09;
	localparam logic [7:0] OFS_DST_A = 8'h0A;
	localparam logic [7:0] OFS_SRC_B = 8'h0B;
	localparam logic [7:0] OFS_DST_B = 8'h0C;
	localparam logic [7:0] OFS_TIM = 8'h0D;
	localparam logic [7:0] OFS_GPIO = 8'h0E;
	localparam logic [7:0] OFS_DET_THR = 8'h0F;
	localparam logic [7:0] OFS_DET_CNT = 8'h10;
	localparam logic [7:0] OFS_COR_THR = 8'h11;
	localparam logic [7:0] OFS_COR_CNT = 8'h12;
	// Values after reset
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [6:0] RST_XLATE = 7'h00;
	localparam logic [7:0] RST_TIM = 8'h36;
	localparam logic [7:0] RST_GPIO = 8'h6A;
	localparam logic [7:0] RST_THR = 8'h00;
	localparam logic [7:0] RST_RDATA = 8'h00;
	// Writable bits of the sync and error control register
	localparam logic [7:0] CTRL_WMASK = 8'hDF;
	// Field positions
	localparam int unsigned B_VS_INV = 7;
	localparam int unsigned B_HS_INV = 6;
	localparam int unsigned B_EQ_FLAG = 4;
	localparam int unsigned B_STAG_DIS = 3;
	localparam int unsigned B_AUTOCLR = 2;
	localparam int unsigned B_LOCACK = 7;
	localparam int unsigned B_GPI_EN = 5;
	localparam int unsigned B_B_DRV = 3;
	localparam int unsigned B_A_DRV = 1;
	// Counter width and synchroniser width in bits
	localparam int unsigned CNT_W = 8;
	localparam int unsigned SYNC_W = 4;
	// Cycles after reset release before the synchronised strap is valid
	localparam logic [1:0] STRAP_WAIT = 2'h2;
	// Error source selections
	typedef enum logic [1:0] {
		ESEL_DETECTED = 2'h0,
		ESEL_CORRECTED = 2'h1,
		ESEL_EITHER = 2'h2,
		ESEL_BOTH = 2'h3
	} dcr_esel_e;
endpackage : dcr_pkg

// file: verilog/dcr_regs_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_regs_top import dcr_pkg::*; (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	// Register access from the control channel
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [7:0] REG_RDATA_O,
	output logic REG_RVALID_O,
	// Sync signals in and out
	input wire logic VSYNC_I,
	input wire logic HSYNC_I,
	output logic VSYNC_O,
	output logic HSYNC_O,
	// Link error events and error pin
	input wire logic DET_ERR_I,
	input wire logic CORR_ERR_I,
	output logic ERR_O,
	// Startup strap, rate-equal flag and stagger disable
	input wire logic DOUBLE_RATE_PIN_I,
	output logic DOUBLE_RATE_SELECT_O,
	output logic RATE_SETTING_EQUAL_O,
	output logic STAGGER_DISABLE_O,
	// Address translation entries
	output logic [6:0] XLATE_SRC_FIRST_O,
	output logic [6:0] XLATE_DST_FIRST_O,
	output logic [6:0] XLATE_SRC_SECOND_O,
	output logic [6:0] XLATE_DST_SECOND_O,
	// Control channel timing
	output logic LOCAL_ACK_ENABLE_O,
	output logic [1:0] SLAVE_SETUP_HOLD_SEL_O,
	output logic [2:0] MASTER_BITRATE_SEL_O,
	output logic [1:0] SLAVE_TIMEOUT_SEL_O,
	// General-purpose input and its forwarded level
	input wire logic GPI_PIN_I,
	output logic GPI_FORWARD_O,
	// First port pin
	input wire logic PIO_A_I,
	output logic PIO_A_O,
	output logic PIO_A_OE_O,
	// Second port pin
	input wire logic PIO_B_I,
	output logic PIO_B_O,
	output logic PIO_B_OE_O
);
	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0] ctrl_r, ctrl_nxt;
	logic [6:0] xlate_r [0:3];
	logic [6:0] xlate_nxt [0:3];
	logic [7:0] tim_r, tim_nxt;
	logic gpi_en_r, gpi_en_nxt;
	logic a_drv_r, a_drv_nxt;
	logic b_drv_r, b_drv_nxt;
	logic a_oe_r, a_oe_nxt;
	logic b_oe_r, b_oe_nxt;
	logic [7:0] det_thr_r, det_thr_nxt;
	logic [7:0] cor_thr_r, cor_thr_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic dbl_r, dbl_nxt;
	logic strap_done_r, strap_done_nxt;
	logic [1:0] strap_wait_r, strap_wait_nxt;
	logic vs_r, vs_nxt;
	logic hs_r, hs_nxt;
	logic err_r, err_nxt;
	logic gpi_fwd_r, gpi_fwd_nxt;
	logic [SYNC_W-1:0] pin_sync;
	logic dbl_sync, gpi_lvl, a_lvl, b_lvl;
	logic det_hit, cor_hit, autoclr;
	logic [1:0] xlate_idx;
	dcr_esel_e esel;

	dcr_cnt_if #(.W(CNT_W)) det_if ();
	dcr_cnt_if #(.W(CNT_W)) cor_if ();

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Threshold reached by a non-zero count
	function automatic logic thr_hit(input logic [7:0] cnt, input logic [7:0] thr);
		thr_hit = (cnt != 8'h00) && (cnt >= thr);
	endfunction : thr_hit

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and error counters

	// Strap, input and port pins come from outside the clock domain
	dcr_sync #(.W(SYNC_W)) u_pin_sync (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.d_i({DOUBLE_RATE_PIN_I, GPI_PIN_I, PIO_A_I, PIO_B_I}),
		.q_o(pin_sync)
	);

	assign dbl_sync = pin_sync[3];
	assign gpi_lvl = pin_sync[2];
	assign a_lvl = pin_sync[1];
	assign b_lvl = pin_sync[0];

	// Autoclear: reading a count register clears it
	assign autoclr = ctrl_r[B_AUTOCLR];
	assign det_if.inc = DET_ERR_I;
	assign det_if.clr = autoclr && REG_RD_I && REG_ADDR_I == OFS_DET_CNT;
	assign cor_if.inc = CORR_ERR_I;
	assign cor_if.clr = autoclr && REG_RD_I && REG_ADDR_I == OFS_COR_CNT;

	// Detected-error counter
	dcr_err_counter #(.W(CNT_W)) u_det_cnt (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.cnt_if(det_if)
	);

	// Corrected-error counter
	dcr_err_counter #(.W(CNT_W)) u_cor_cnt (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.cnt_if(cor_if)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	assign xlate_idx = 2'(REG_ADDR_I - OFS_SRC_A);

	// Write decode; reserved bits keep their defaults
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		xlate_nxt = xlate_r;
		tim_nxt = tim_r;
		gpi_en_nxt = gpi_en_r;
		a_drv_nxt = a_drv_r;
		b_drv_nxt = b_drv_r;
		det_thr_nxt = det_thr_r;
		cor_thr_nxt = cor_thr_r;
		if (REG_WR_I)
		begin
			if (REG_ADDR_I == OFS_CTRL)
				ctrl_nxt = (REG_WDATA_I & CTRL_WMASK) | (RST_CTRL & ~CTRL_WMASK);
			else if (REG_ADDR_I >= OFS_SRC_A && REG_ADDR_I <= OFS_DST_B)
				xlate_nxt[xlate_idx] = REG_WDATA_I[7:1];
			else if (REG_ADDR_I == OFS_TIM)
				tim_nxt = REG_WDATA_I;
			else if (REG_ADDR_I == OFS_GPIO)
			begin
				gpi_en_nxt = REG_WDATA_I[B_GPI_EN];
				b_drv_nxt = REG_WDATA_I[B_B_DRV];
				a_drv_nxt = REG_WDATA_I[B_A_DRV];
			end
			else if (REG_ADDR_I == OFS_DET_THR)
				det_thr_nxt = REG_WDATA_I;
			else if (REG_ADDR_I == OFS_COR_THR)
				cor_thr_nxt = REG_WDATA_I;
		end
	end

	// Configuration storage
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			ctrl_r <= RST_CTRL;
			for (int i = 0; i < 4; i++)
				xlate_r[i] <= RST_XLATE;
			tim_r <= RST_TIM;
			gpi_en_r <= RST_GPIO[B_GPI_EN];
			a_drv_r <= RST_GPIO[B_A_DRV];
			b_drv_r <= RST_GPIO[B_B_DRV];
			det_thr_r <= RST_THR;
			cor_thr_r <= RST_THR;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			xlate_r <= xlate_nxt;
			tim_r <= tim_nxt;
			gpi_en_r <= gpi_en_nxt;
			a_drv_r <= a_drv_nxt;
			b_drv_r <= b_drv_nxt;
			det_thr_r <= det_thr_nxt;
			cor_thr_r <= cor_thr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	// Read decode; unmapped addresses read zero
	always_comb
	begin
		rvalid_nxt = REG_RD_I;
		rdata_nxt = rdata_r;
		if (REG_RD_I)
		begin
			if (REG_ADDR_I == OFS_CTRL)
				rdata_nxt = ctrl_r;
			else if (REG_ADDR_I >= OFS_SRC_A && REG_ADDR_I <= OFS_DST_B)
				rdata_nxt = {xlate_r[xlate_idx], 1'b0};
			else if (REG_ADDR_I == OFS_TIM)
				rdata_nxt = tim_r;
			else if (REG_ADDR_I == OFS_GPIO)
				rdata_nxt = {RST_GPIO[7:6], gpi_en_r, gpi_lvl, b_drv_r, b_lvl, a_drv_r, a_lvl};
			else if (REG_ADDR_I == OFS_DET_THR)
				rdata_nxt = det_thr_r;
			else if (REG_ADDR_I == OFS_DET_CNT)
				rdata_nxt = det_if.cnt;
			else if (REG_ADDR_I == OFS_COR_THR)
				rdata_nxt = cor_thr_r;
			else if (REG_ADDR_I == OFS_COR_CNT)
				rdata_nxt = cor_if.cnt;
			else
				rdata_nxt = RST_RDATA;
		end
	end

	// Read data holds until the next read
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			rdata_r <= RST_RDATA;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Startup strap

	// Capture the strap once; the synchroniser is cleared by reset and needs two edges to refill
	always_comb
	begin
		dbl_nxt = dbl_r;
		strap_done_nxt = strap_done_r;
		strap_wait_nxt = strap_wait_r;
		if (!strap_done_r)
		begin
			if (strap_wait_r == STRAP_WAIT)
			begin
				dbl_nxt = dbl_sync;
				strap_done_nxt = 1'b1;
			end
			else
				strap_wait_nxt = strap_wait_r + 2'h1;
		end
	end

	// Strap storage
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			dbl_r <= 1'b0;
			strap_done_r <= 1'b0;
			strap_wait_r <= 2'h0;
		end
		else
		begin
			dbl_r <= dbl_nxt;
			strap_done_r <= strap_done_nxt;
			strap_wait_r <= strap_wait_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sync, error and pin outputs

	assign esel = dcr_esel_e'(ctrl_r[1:0]);
	assign det_hit = thr_hit(det_if.cnt, det_thr_r);
	assign cor_hit = thr_hit(cor_if.cnt, cor_thr_r);

	// Output values; ports are open drain, enabled while driving low
	always_comb
	begin
		vs_nxt = VSYNC_I ^ ctrl_r[B_VS_INV];
		hs_nxt = HSYNC_I ^ ctrl_r[B_HS_INV];
		gpi_fwd_nxt = gpi_en_r & gpi_lvl;
		a_oe_nxt = ~a_drv_nxt;
		b_oe_nxt = ~b_drv_nxt;
		case (esel)
			ESEL_DETECTED: err_nxt = det_hit;
			ESEL_CORRECTED: err_nxt = cor_hit;
			ESEL_EITHER: err_nxt = det_hit | cor_hit;
			ESEL_BOTH: err_nxt = det_hit & cor_hit;
			default: err_nxt = det_hit;
		endcase
	end

	// Output registers
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			vs_r <= 1'b0;
			hs_r <= 1'b0;
			err_r <= 1'b0;
			gpi_fwd_r <= 1'b0;
			a_oe_r <= ~RST_GPIO[B_A_DRV];
			b_oe_r <= ~RST_GPIO[B_B_DRV];
		end
		else
		begin
			vs_r <= vs_nxt;
			hs_r <= hs_nxt;
			err_r <= err_nxt;
			gpi_fwd_r <= gpi_fwd_nxt;
			a_oe_r <= a_oe_nxt;
			b_oe_r <= b_oe_nxt;
		end
	end

	// Port map
	assign REG_RDATA_O = rdata_r;
	assign REG_RVALID_O = rvalid_r;
	assign VSYNC_O = vs_r;
	assign HSYNC_O = hs_r;
	assign ERR_O = err_r;
	assign DOUBLE_RATE_SELECT_O = dbl_r;
	assign RATE_SETTING_EQUAL_O = ctrl_r[B_EQ_FLAG];
	assign STAGGER_DISABLE_O = ctrl_r[B_STAG_DIS];
	assign XLATE_SRC_FIRST_O = xlate_r[0];
	assign XLATE_DST_FIRST_O = xlate_r[1];
	assign XLATE_SRC_SECOND_O = xlate_r[2];
	assign XLATE_DST_SECOND_O = xlate_r[3];
	assign LOCAL_ACK_ENABLE_O = tim_r[B_LOCACK];
	assign SLAVE_SETUP_HOLD_SEL_O = tim_r[6:5];
	assign MASTER_BITRATE_SEL_O = tim_r[4:2];
	assign SLAVE_TIMEOUT_SEL_O = tim_r[1:0];
	assign GPI_FORWARD_O = gpi_fwd_r;
	assign PIO_A_O = a_drv_r;
	assign PIO_A_OE_O = a_oe_r;
	assign PIO_B_O = b_drv_r;
	assign PIO_B_OE_O = b_oe_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	vs_invert_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		1'b1 |=> VSYNC_O == ($past(VSYNC_I) ^ $past(ctrl_r[B_VS_INV])))
		else $error("vsync inversion wrong");
	reset_defaults_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		$rose(RST_N_I) |-> (ctrl_r == RST_CTRL && tim_r == RST_TIM && gpi_en_r && a_drv_r && b_drv_r))
		else $error("register default wrong after reset");
	gpi_readback_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(REG_RD_I && REG_ADDR_I == OFS_GPIO) |=> REG_RDATA_O[4] == $past(gpi_lvl) && REG_RVALID_O)
		else $error("input level readback wrong");
	err_select_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(esel == ESEL_DETECTED) |=> ERR_O == $past(det_hit))
		else $error("error pin does not follow detected errors");
	det_ro_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(REG_WR_I && REG_ADDR_I == OFS_DET_CNT && !DET_ERR_I && !det_if.clr) |=> $stable(det_if.cnt))
		else $error("write changed detected count");
	reserved_read_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(REG_RD_I && REG_ADDR_I == OFS_GPIO) |=> REG_RDATA_O[7:6] == RST_GPIO[7:6])
		else $error("reserved bits read wrong");
	autoclear_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(autoclr && REG_RD_I && REG_ADDR_I == OFS_DET_CNT && !DET_ERR_I) |=> det_if.cnt == 8'h00)
		else $error("autoclear did not clear detected count");
	strap_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		strap_done_r |=> $stable(dbl_r) && strap_done_r)
		else $error("latched double-rate selection changed");
endmodule : dcr_regs_top
`default_nettype wire

// file: verilog/dcr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_sync import dcr_pkg::*; #(
	parameter int W = SYNC_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r, meta_nxt, sync_r, sync_nxt;

	if (W < 1)
	begin : g_chk
		$error("dcr_sync width must be at least one");
	end

	// First stage feeds only the second
	always_comb
	begin
		meta_nxt = d_i;
		sync_nxt = meta_r;
	end

	// Two-stage register chain
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign q_o = sync_r;
endmodule : dcr_sync
`default_nettype wire
